//--- hdl/sfr_consts.svh
// Constants of the serial flash read path: opcodes, phase lengths, array bounds.
// Included by the read path; holds definitions only.
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// Command opcodes
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST_READ 8'h0b
`define SFR_OP_DUAL_OUT 8'h3b
`define SFR_OP_DUAL_IO 8'hbb
`define SFR_OP_QUAD_OUT 8'h6b
// Continuous read mode reset opcode, value chosen here
`define SFR_OP_MODE_RESET 8'hff

// Phase lengths in serial clocks, minus one for the terminal count
`define SFR_OP_LAST 5'h07
`define SFR_ADDR1_LAST 5'h17
`define SFR_ADDR2_LAST 5'h0b
`define SFR_MODE2_LAST 5'h03
`define SFR_DUMMY_LAST 5'h07
// Dual clocks after which an all-ones skip-mode address is a mode reset
`define SFR_RESET2_CLKS 5'h08

// Array bounds
`define SFR_ARRAY_LAST 24'h7fffff
`define SFR_ARRAY_FIRST 24'h000000

// Opcode-skip field of the mode byte and the value that arms it
`define SFR_SKIP_MSB 5
`define SFR_SKIP_LSB 4
`define SFR_SKIP_ARM 2'h2
`define SFR_MODE_RST_VAL 8'h00

// Lane enables
`define SFR_OE_SINGLE 4'h2
`define SFR_OE_DUAL 4'h3
`define SFR_OE_QUAD 4'hf

// Synchroniser reset value: select high, clock and data low
`define SFR_SYNC_RST 6'h01

`endif

//--- hdl/sfr_pkg.sv
// Types shared by the serial flash read path.
// Assumes nothing beyond a SystemVerilog compiler.
package sfr_pkg;

  typedef enum logic [2:0] {
    sfr_st_idle,
    sfr_st_op,
    sfr_st_addr,
    sfr_st_mode,
    sfr_st_dummy,
    sfr_st_data,
    sfr_st_ignore
  } sfr_state_t;

  typedef enum logic [1:0] {
    sfr_lanes_one,
    sfr_lanes_two,
    sfr_lanes_four
  } sfr_lanes_t;

endpackage

//--- hdl/sfr_sync.sv
// Two flip-flop synchroniser for a group of unrelated asynchronous levels.
// Assumes each bit is a slow level or a clock far below clock_i.
`timescale 1ns/100ps

module sfr_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          meta_r[gi] <= RST_VAL[gi];
          sync_r[gi] <= RST_VAL[gi];
        end else begin
          meta_r[gi] <= async_i[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  assign sync_o = sync_r;

endmodule

//--- hdl/sfr_read_path.sv
// Device-side read command path of a serial flash: decodes single, dual and
// quad read commands and streams array bytes onto the data lines.
// Assumes the array answers mem_addr_o with mem_data_i within a few clock_i
// cycles, and that the serial clock is far slower than clock_i.
`timescale 1ns/100ps
`include "sfr_consts.svh"

// Behaviour
// - Frame opens with read opcode 0Bh or 03h, then 24-bit address MSB first.
// - 0Bh read needs one dummy byte after address; 03h has none.
// - Single reads shift bytes MSB first on serial_out while clocked.
// - Address advances per byte and wraps 7FFFFFh to 000000h without delay.
// - Select rising ends the read and floats every driven data line.
// - Select may rise anywhere, mid-byte included, with no error.
// - Dual-output read: opcode 3Bh, address, dummy byte all on serial_in.
// - Dual data: high bit on serial_out, low on serial_in; four clocks per byte.
// - Dual-address read BBh: address two bits per clock, mode byte, then data.
// - Mode bits 5:4 equal 10 make next frame start directly with address.
// - Other mode bits 5:4 values restore full opcode decoding next frame.
// - Low nibble of the mode byte is ignored.
// - Mode reset command clears all eight mode bits; opcodes required again.
// - Quad-output read 6Bh: opcode, address, dummy byte sampled on rising clock.
// - Quad data: four bits per clock, any start byte, address increments per byte.
// - Quad data: bits 7:4 then 3:0 on quad lines 3:0.
// - Opcode 8 clocks; dual address 12 clocks; dual mode byte 4 clocks.
module sfr_read_path (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic select_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] quad_data_lines_i,
  input wire logic [7:0] mem_data_i,
  output logic [3:0] quad_data_lines_o,
  output logic [3:0] quad_data_lines_oe_o,
  output logic [23:0] mem_addr_o,
  output logic [7:0] continuous_mode_bits_o,
  output logic read_active_o
);

  // Synchronised pins
  logic [5:0] pins_s;
  logic sel_n_s;
  logic sclk_s;
  logic [3:0] din_s;

  sfr_sync #(
    .W(6),
    .RST_VAL(`SFR_SYNC_RST)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({quad_data_lines_i, sclk_i, select_n_i}),
    .sync_o(pins_s)
  );

  assign sel_n_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[5:2];

  // Edge detection on the synchronised copies only
  logic sclk_d_r;
  logic sel_n_d_r;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign frame_start = sel_n_d_r & ~sel_n_s;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_d_r <= 1'b0;
      sel_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      sel_n_d_r <= sel_n_s;
    end
  end

  // Command state
  sfr_pkg::sfr_state_t state_r, state_nxt;
  sfr_pkg::sfr_lanes_t lanes_r, lanes_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [7:0] op_r, op_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] cmode_r, cmode_nxt;
  logic dual_addr_r, dual_addr_nxt;
  logic need_dummy_r, need_dummy_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic [2:0] bitpos_r, bitpos_nxt;
  logic [23:0] mem_addr_r, mem_addr_nxt;
  logic [3:0] out_r, out_nxt;
  logic [3:0] oe_r, oe_nxt;
  logic active_r, active_nxt;

  // Scratch values of the combinational process
  logic [7:0] op_full;
  logic [23:0] addr_full;
  logic [7:0] mode_full;
  logic [7:0] src;

  function automatic logic [23:0] sfr_next_addr(input logic [23:0] a);
    if (a >= `SFR_ARRAY_LAST) begin
      sfr_next_addr = `SFR_ARRAY_FIRST;
    end else begin
      sfr_next_addr = a + 24'h000001;
    end
  endfunction

  always_comb begin
    op_full = {op_r[6:0], din_s[0]};
    addr_full = dual_addr_r ? {addr_r[21:0], din_s[1], din_s[0]}
                            : {addr_r[22:0], din_s[0]};
    mode_full = {mode_r[5:0], din_s[1], din_s[0]};
    src = (bitpos_r == 3'h0) ? mem_data_i : byte_r;

    state_nxt = state_r;
    lanes_nxt = lanes_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    mode_nxt = mode_r;
    cmode_nxt = cmode_r;
    dual_addr_nxt = dual_addr_r;
    need_dummy_nxt = need_dummy_r;
    byte_nxt = byte_r;
    bitpos_nxt = bitpos_r;
    mem_addr_nxt = mem_addr_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    active_nxt = active_r;

    if (sel_n_s) begin
      // Abort at any point; partial bytes are simply dropped
      state_nxt = sfr_pkg::sfr_st_idle;
      oe_nxt = 4'h0;
      out_nxt = 4'h0;
      active_nxt = 1'b0;
      cnt_nxt = 5'h00;
      // Skip-mode frame of all ones on both lines acts as the mode reset
      if (state_r == sfr_pkg::sfr_st_addr && dual_addr_r && cnt_r == `SFR_RESET2_CLKS &&
          addr_r[15:0] == 16'hffff) begin
        cmode_nxt = `SFR_MODE_RST_VAL;
      end
    end else if (frame_start) begin
      cnt_nxt = 5'h00;
      bitpos_nxt = 3'h0;
      addr_nxt = 24'h000000;
      active_nxt = 1'b1;
      if (cmode_r[`SFR_SKIP_MSB:`SFR_SKIP_LSB] == `SFR_SKIP_ARM) begin
        // Previous mode byte armed opcode skip
        state_nxt = sfr_pkg::sfr_st_addr;
        op_nxt = `SFR_OP_DUAL_IO;
        dual_addr_nxt = 1'b1;
        need_dummy_nxt = 1'b0;
        lanes_nxt = sfr_pkg::sfr_lanes_two;
      end else begin
        state_nxt = sfr_pkg::sfr_st_op;
        op_nxt = 8'h00;
      end
    end else begin
      unique case (state_r)
        sfr_pkg::sfr_st_idle: begin
          state_nxt = sfr_pkg::sfr_st_idle;
        end
        sfr_pkg::sfr_st_op: begin
          if (sclk_rise) begin
            op_nxt = op_full;
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `SFR_OP_LAST) begin
              cnt_nxt = 5'h00;
              state_nxt = sfr_pkg::sfr_st_addr;
              dual_addr_nxt = 1'b0;
              need_dummy_nxt = 1'b1;
              lanes_nxt = sfr_pkg::sfr_lanes_one;
              case (op_full)
                `SFR_OP_READ: begin
                  need_dummy_nxt = 1'b0;
                end
                `SFR_OP_FAST_READ: begin
                  need_dummy_nxt = 1'b1;
                end
                `SFR_OP_DUAL_OUT: begin
                  lanes_nxt = sfr_pkg::sfr_lanes_two;
                end
                `SFR_OP_QUAD_OUT: begin
                  lanes_nxt = sfr_pkg::sfr_lanes_four;
                end
                `SFR_OP_DUAL_IO: begin
                  dual_addr_nxt = 1'b1;
                  need_dummy_nxt = 1'b0;
                  lanes_nxt = sfr_pkg::sfr_lanes_two;
                end
                `SFR_OP_MODE_RESET: begin
                  cmode_nxt = `SFR_MODE_RST_VAL;
                  state_nxt = sfr_pkg::sfr_st_ignore;
                end
                default: begin
                  // Commands outside this path leave the lines floating
                  state_nxt = sfr_pkg::sfr_st_ignore;
                end
              endcase
            end
          end
        end
        sfr_pkg::sfr_st_addr: begin
          if (sclk_rise) begin
            addr_nxt = addr_full;
            cnt_nxt = cnt_r + 5'h01;
            if ((dual_addr_r && cnt_r == `SFR_ADDR2_LAST) ||
                (!dual_addr_r && cnt_r == `SFR_ADDR1_LAST)) begin
              cnt_nxt = 5'h00;
              // Array holds fewer bytes than 24 bits address
              mem_addr_nxt = addr_full & `SFR_ARRAY_LAST;
              if (dual_addr_r) begin
                state_nxt = sfr_pkg::sfr_st_mode;
              end else if (need_dummy_r) begin
                state_nxt = sfr_pkg::sfr_st_dummy;
              end else begin
                state_nxt = sfr_pkg::sfr_st_data;
              end
            end
          end
        end
        sfr_pkg::sfr_st_mode: begin
          if (sclk_rise) begin
            mode_nxt = mode_full;
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `SFR_MODE2_LAST) begin
              cnt_nxt = 5'h00;
              // Only bits 5:4 are ever tested later
              cmode_nxt = mode_full;
              state_nxt = sfr_pkg::sfr_st_data;
            end
          end
        end
        sfr_pkg::sfr_st_dummy: begin
          // Contents discarded, lines left floating
          if (sclk_rise) begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `SFR_DUMMY_LAST) begin
              cnt_nxt = 5'h00;
              state_nxt = sfr_pkg::sfr_st_data;
            end
          end
        end
        sfr_pkg::sfr_st_data: begin
          // Host has floated shared lines by now; drive on falling edge only
          if (sclk_fall) begin
            if (bitpos_r == 3'h0) begin
              mem_addr_nxt = sfr_next_addr(mem_addr_r);
            end
            unique case (lanes_r)
              sfr_pkg::sfr_lanes_one: begin
                out_nxt = {2'h0, src[7], 1'b0};
                oe_nxt = `SFR_OE_SINGLE;
                byte_nxt = {src[6:0], 1'b0};
                bitpos_nxt = bitpos_r + 3'h1;
              end
              sfr_pkg::sfr_lanes_two: begin
                out_nxt = {2'h0, src[7], src[6]};
                oe_nxt = `SFR_OE_DUAL;
                byte_nxt = {src[5:0], 2'h0};
                bitpos_nxt = bitpos_r + 3'h2;
              end
              sfr_pkg::sfr_lanes_four: begin
                out_nxt = src[7:4];
                oe_nxt = `SFR_OE_QUAD;
                byte_nxt = {src[3:0], 4'h0};
                bitpos_nxt = bitpos_r + 3'h4;
              end
              default: begin
                out_nxt = 4'h0;
                oe_nxt = 4'h0;
              end
            endcase
          end
        end
        sfr_pkg::sfr_st_ignore: begin
          state_nxt = sfr_pkg::sfr_st_ignore;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= sfr_pkg::sfr_st_idle;
      lanes_r <= sfr_pkg::sfr_lanes_one;
      cnt_r <= 5'h00;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      mode_r <= 8'h00;
      cmode_r <= `SFR_MODE_RST_VAL;
      dual_addr_r <= 1'b0;
      need_dummy_r <= 1'b0;
      byte_r <= 8'h00;
      bitpos_r <= 3'h0;
      mem_addr_r <= 24'h000000;
      out_r <= 4'h0;
      oe_r <= 4'h0;
      active_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      lanes_r <= lanes_nxt;
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      mode_r <= mode_nxt;
      cmode_r <= cmode_nxt;
      dual_addr_r <= dual_addr_nxt;
      need_dummy_r <= need_dummy_nxt;
      byte_r <= byte_nxt;
      bitpos_r <= bitpos_nxt;
      mem_addr_r <= mem_addr_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      active_r <= active_nxt;
    end
  end

  assign quad_data_lines_o = out_r;
  assign quad_data_lines_oe_o = oe_r;
  assign mem_addr_o = mem_addr_r;
  assign continuous_mode_bits_o = cmode_r;
  assign read_active_o = active_r;

endmodule

//--- bench/sfr_read_path_sva.sv
// Checker for the serial flash read path, watching top-level ports only.
// Assumes the bench keeps the serial clock far slower than clock_i.
`timescale 1ns/100ps
`include "sfr_consts.svh"

module sfr_read_path_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic select_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] quad_data_lines_i,
  input wire logic [7:0] mem_data_i,
  input wire logic [3:0] quad_data_lines_o,
  input wire logic [3:0] quad_data_lines_oe_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic [7:0] continuous_mode_bits_o,
  input wire logic read_active_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_FLOAT_DESELECTED: assert property (select_n_i [*6] |-> quad_data_lines_oe_o == 4'h0)
    else $error("data lines driven while deselected");
  AST_LANE_SET: assert property (quad_data_lines_oe_o inside {4'h0, `SFR_OE_SINGLE,
    `SFR_OE_DUAL, `SFR_OE_QUAD}) else $error("illegal lane enable pattern");
  AST_OUT_ON_FALL: assert property ($changed(quad_data_lines_o) && $past(|quad_data_lines_oe_o)
    && |quad_data_lines_oe_o |-> !sclk_i) else $error("data changed with serial clock high");
  AST_OE_START: assert property ($rose(|quad_data_lines_oe_o) |-> !sclk_i && !select_n_i)
    else $error("drive began outside a falling clock phase");
  AST_ADDR_STEP: assert property ($past(|quad_data_lines_oe_o) && |quad_data_lines_oe_o
    && $changed(mem_addr_o) |-> mem_addr_o == (($past(mem_addr_o) == `SFR_ARRAY_LAST) ?
    `SFR_ARRAY_FIRST : $past(mem_addr_o) + 24'h000001)) else $error("bad address step");
  AST_ACTIVE_SELECTED: assert property (!select_n_i [*5] |-> read_active_o)
    else $error("not active while selected");
  AST_IDLE_DESELECTED: assert property (select_n_i [*5] |-> !read_active_o)
    else $error("active while deselected");
  AST_MODE_IN_FRAME: assert property ($changed(continuous_mode_bits_o) |-> read_active_o
    || $past(read_active_o) || $past(read_active_o, 2)) else $error("mode bits changed idle");

  cover property ($rose(quad_data_lines_oe_o == `SFR_OE_QUAD));
  cover property ($rose(quad_data_lines_oe_o == `SFR_OE_DUAL));
  cover property ($past(mem_addr_o) == `SFR_ARRAY_LAST && mem_addr_o == `SFR_ARRAY_FIRST);
endmodule

bind sfr_read_path sfr_read_path_chk chk_i (.clock_i(clock_i), .rst_i(rst_i),
  .select_n_i(select_n_i), .sclk_i(sclk_i), .quad_data_lines_i(quad_data_lines_i),
  .mem_data_i(mem_data_i), .quad_data_lines_o(quad_data_lines_o),
  .quad_data_lines_oe_o(quad_data_lines_oe_o), .mem_addr_o(mem_addr_o),
  .continuous_mode_bits_o(continuous_mode_bits_o), .read_active_o(read_active_o));

//--- bench/sfr_host_model.sv
// Host controller model: drives select, mode 0 serial clock and command bits.
// Assumes the bench resolves line levels from both parties' enables.
`timescale 1ns/100ps

module sfr_host_model (
  input wire logic clock_i,
  input wire logic [3:0] line_i,
  output logic select_n_o,
  output logic sclk_o,
  output logic [3:0] drive_o,
  output logic [3:0] drive_oe_o
);
  initial begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    drive_o = 4'h0;
    drive_oe_o = 4'h0;
  end

  // Half serial period of 40 ns
  task automatic half();
    repeat (10) @(posedge clock_i);
  endtask

  task automatic start();
    @(posedge clock_i);
    select_n_o <= 1'b0;
    half();
  endtask

  task automatic stop();
    half();
    select_n_o <= 1'b1;
    drive_oe_o <= 4'h0;
    repeat (3) half();
  endtask

  // One bit, bit pair or nibble per clock; sampling on the rising edge
  task automatic xfer(input logic [31:0] tx, input int n, input int lanes, input bit drv,
                      output logic [31:0] rx);
    rx = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      drive_o <= (lanes == 2) ? {2'h0, tx[2*i+:2]} : {3'h0, tx[i]};
      drive_oe_o <= !drv ? 4'h0 : (lanes == 2) ? 4'h3 : 4'h1;
      half();
      sclk_o <= 1'b1;
      case (lanes)
        1: rx = {rx[30:0], line_i[1]};
        2: rx = {rx[29:0], line_i[1:0]};
        default: rx = {rx[27:0], line_i};
      endcase
      // Released well before the falling edge that may start device output
      repeat (5) @(posedge clock_i);
      drive_oe_o <= 4'h0;
      repeat (5) @(posedge clock_i);
      sclk_o <= 1'b0;
    end
  endtask
endmodule

//--- bench/test_serial_flash_read_path.sv
// Self-checking bench for the serial flash read path with a host model.
// Assumes sfr_host_model and the checker bind are compiled alongside.
`timescale 1ns/100ps

module test_serial_flash_read_path;
  logic clock_i;
  logic rst_i;
  logic select_n;
  logic sclk;
  logic flip_r = 1'b0;
  logic [3:0] hd, hoe, line, dut_out, dut_oe;
  logic [7:0] mem_data = 8'h00;
  logic [7:0] mode;
  logic [23:0] mem_addr;
  logic act;
  int error_cnt = 0;
  int check_count = 0;

  // Undriven lines toggle so a stale level is never read as data
  assign line = (dut_oe & dut_out) | (~dut_oe & hoe & hd) | (~dut_oe & ~hoe & {4{flip_r}});

  function automatic logic [7:0] arr(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction

  always @(posedge clock_i) begin
    flip_r <= ~flip_r;
    mem_data <= arr(mem_addr);
  end

  sfr_read_path dut (.clock_i(clock_i), .rst_i(rst_i), .select_n_i(select_n), .sclk_i(sclk),
    .quad_data_lines_i(line), .mem_data_i(mem_data), .quad_data_lines_o(dut_out),
    .quad_data_lines_oe_o(dut_oe), .mem_addr_o(mem_addr), .continuous_mode_bits_o(mode),
    .read_active_o(act));
  sfr_host_model host (.clock_i(clock_i), .line_i(line), .select_n_o(select_n), .sclk_o(sclk),
    .drive_o(hd), .drive_oe_o(hoe));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input bit dum);
    logic [31:0] rx;
    host.start();
    host.xfer({24'h0, op}, 8, 1, 1'b1, rx);
    host.xfer({8'h0, a}, 24, 1, 1'b1, rx);
    if (dum) host.xfer(32'h5a, 8, 1, 1'b1, rx);
  endtask

  task automatic t_single();
    logic [31:0] rx;
    logic [7:0] e;
    cmd(8'h03, 24'h7ffffe, 1'b0);
    host.xfer(32'h0, 24, 1, 1'b0, rx);
    chk(rx, {8'h0, arr(24'h7ffffe), arr(24'h7fffff), arr(24'h000000)});
    host.xfer(32'h0, 3, 1, 1'b0, rx);
    e = arr(24'h000001);
    chk(rx, {29'h0, e[7:5]});
    chk({31'h0, act}, 32'h1);
    host.stop();
    chk({28'h0, dut_oe}, 32'h0);
    chk({31'h0, act}, 32'h0);
    cmd(8'hc3, 24'h000010, 1'b1);
    host.xfer(32'h0, 8, 1, 1'b0, rx);
    chk({28'h0, dut_oe}, 32'h0);
    host.stop();
    $display("test single done");
  endtask

  task automatic t_fast();
    logic [31:0] rx;
    logic [23:0] a;
    logic [7:0] ops [3] = '{8'h0b, 8'h3b, 8'h6b};
    for (int k = 0; k < 3; k++) begin
      a = 24'h0abc00 + 24'(k);
      cmd(ops[k], a, 1'b1);
      host.xfer(32'h0, 16 >> k, 1 << k, 1'b0, rx);
      chk(rx, {16'h0, arr(a), arr(a + 24'h000001)});
      host.stop();
    end
    $display("test fast done");
  endtask

  task automatic t_dual_io();
    logic [31:0] rx;
    host.start();
    host.xfer(32'hbb, 8, 1, 1'b1, rx);
    host.xfer(32'h00f0f0, 12, 2, 1'b1, rx);
    host.xfer(32'ha5, 4, 2, 1'b1, rx);
    host.xfer(32'h0, 4, 2, 1'b0, rx);
    chk(rx, {24'h0, arr(24'h00f0f0)});
    host.stop();
    chk({24'h0, mode}, 32'ha5);
    host.start();
    host.xfer(32'h000200, 12, 2, 1'b1, rx);
    host.xfer(32'h30, 4, 2, 1'b1, rx);
    host.xfer(32'h0, 8, 2, 1'b0, rx);
    chk(rx, {16'h0, arr(24'h000200), arr(24'h000201)});
    host.stop();
    cmd(8'h03, 24'h000300, 1'b0);
    host.xfer(32'h0, 8, 1, 1'b0, rx);
    chk(rx, {24'h0, arr(24'h000300)});
    host.stop();
    // Mode bits still hold 30h here, so the reset opcode has something to clear
    host.start();
    host.xfer(32'hff, 8, 1, 1'b1, rx);
    host.stop();
    chk({24'h0, mode}, 32'h0);
    $display("test dual io done");
  endtask

  task automatic t_mode_reset();
    logic [31:0] rx;
    host.start();
    host.xfer(32'hbb, 8, 1, 1'b1, rx);
    host.xfer(32'h7ffffe, 12, 2, 1'b1, rx);
    host.xfer(32'h2f, 4, 2, 1'b1, rx);
    host.xfer(32'h0, 12, 2, 1'b0, rx);
    chk(rx, {8'h0, arr(24'h7ffffe), arr(24'h7fffff), arr(24'h000000)});
    host.stop();
    chk({24'h0, mode}, 32'h2f);
    host.start();
    host.xfer(32'hffff, 8, 2, 1'b1, rx);
    host.stop();
    chk({24'h0, mode}, 32'h0);
    cmd(8'h03, 24'h000400, 1'b0);
    host.xfer(32'h0, 8, 1, 1'b0, rx);
    chk(rx, {24'h0, arr(24'h000400)});
    host.stop();
    $display("test mode reset done");
  endtask

  initial begin
    repeat (100000) @(posedge clock_i);
    error_cnt++;
    $display("mismatch at %0t: run too long", $time);
    results();
  end

  initial begin
    rst_i = 1'b1;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    t_single();
    t_fast();
    t_dual_io();
    t_mode_reset();
    results();
  end
endmodule
